// >>> rtl/bls_defines.vh
// Contract
// (RULE1) Overflow-set branch: PC+k+1 when V=1; 1 or 2 cycles; flags untouched.
// (RULE2) Overflow-clear branch: PC+k+1 only when V=0, else fall through.
// (RULE3) Carry-clear branch taken only when C=0; one cycle, two if taken.
// (RULE4) Same-or-higher branch is identical to carry-clear branch.
// (RULE5) Signed greater-or-equal branch taken when N xor V is zero.
// (RULE6) Signed less-than branch taken when N xor V is one.
// (RULE7) Half-carry set branch on H=1, half-carry clear branch on H=0.
// (RULE8) T-set branch on T=1, T-clear branch on T=0; 1 or 2 cycles.
// (RULE9) Interrupt-enabled branch taken when I=1, target PC+k+1, no flags.
// (RULE10) Interrupt-disabled branch taken only when I=0; 1 or 2 cycles.
// (RULE11) Move, pair copy, immediate load: one cycle, destination only.
// (RULE12) Post-increment load reads at pointer, then pointer plus one; 2 cycles.
// (RULE13) Pre-decrement load: pointer minus one, then read new address; 2 cycles.
// (RULE14) Displacement load reads Y or Z plus q; pointer unchanged; 2 cycles.
// (RULE15) Direct load reads byte at instruction address; two cycles. The code reads at the address in the second word, instr_ext.
// (RULE16) Post-increment store writes at pointer, then pointer plus one.
// (RULE17) Pre-decrement store: pointer minus one, then write; two cycles.
// (RULE18) Equal branch taken when Z=1, target PC+k+1, 1 or 2 cycles.
// (RULE19) Not-equal on Z=0, negative on N=1, positive on N=0.
// (RULE20) Plain indirect load/store moves one byte, pointer unchanged, 2 cycles.
`ifndef BLS_DEFINES_VH
`define BLS_DEFINES_VH

// Decoded instruction kinds
`define BLS_K_ILL       3'h0
`define BLS_K_BR        3'h1
`define BLS_K_MOV       3'h2
`define BLS_K_PAIR      3'h3
`define BLS_K_IMM       3'h4
`define BLS_K_MEM       3'h5

// Addressing modes
`define BLS_M_PLAIN     2'h0
`define BLS_M_INC       2'h1
`define BLS_M_DEC       2'h2
`define BLS_M_OFS       2'h3

// Pointer pair selects and base register of the X pair
`define BLS_P_X         2'h0
`define BLS_P_Y         2'h1
`define BLS_P_Z         2'h2
`define BLS_PTR_BASE    5'h1a

// Status flag positions
`define BLS_F_C         3'h0
`define BLS_F_Z         3'h1
`define BLS_F_N         3'h2
`define BLS_F_V         3'h3
`define BLS_F_S         3'h4
`define BLS_F_H         3'h5
`define BLS_F_T         3'h6
`define BLS_F_I         3'h7

// Opcode patterns
`define BLS_OP_BRB      5'h1e
`define BLS_OP_MOV      6'h0b
`define BLS_OP_PAIR     8'h01
`define BLS_OP_IMM      4'he
`define BLS_OP_LDST     6'h24
`define BLS_OP_DISP     2'h2

// Cycle counts
`define BLS_CYC_SHORT   2'h1
`define BLS_CYC_LONG    2'h2

`endif

// >>> rtl/bls_exec.v
`timescale 1ns/100ps
`default_nettype none
`include "bls_defines.vh"

module bls_exec
(
   input  wire        clock,         // Core clock, 50 MHz
   input  wire        rst_n,         // Asynchronous reset, active low
   input  wire        instr_valid,   // Instruction word offered
   input  wire [15:0] instr,         // Instruction word
   input  wire [15:0] instr_ext,     // Second word, address of direct load
   output wire        instr_ready,   // Instruction taken this cycle if valid
   input  wire [7:0]  sreg,          // Status flags, read only here
   output reg  [15:0] pc_reg,        // Program counter, word address
   output reg         done_reg,      // Instruction completed, pulse
   output reg         taken_reg,     // Completed instruction branched, pulse
   output reg         illegal_reg,   // Completed word not handled, pulse
   output reg  [1:0]  cycles_reg,    // Cycles of last completed instruction
   output reg  [15:0] mem_addr_reg,  // Data memory address
   output reg  [7:0]  mem_wdata_reg, // Data memory write data
   output reg         mem_we_reg,    // Data memory write strobe
   output reg         mem_re_reg,    // Data memory read strobe
   input  wire [7:0]  mem_rdata,     // Read data, same cycle as read strobe
   input  wire        load_en,       // Preload a register while idle
   input  wire [4:0]  load_addr,     // Preload register number
   input  wire [7:0]  load_data,     // Preload value
   input  wire [4:0]  dbg_addr,      // Register to observe
   output reg  [7:0]  dbg_data_reg   // Observed register, one cycle later
);

   reg  [7:0]  gpr [0:31];
   reg  [1:0]  state_reg;
   reg  [4:0]  dst_reg;
   reg         store_reg;

   integer     i;

   localparam  STATE_IDLE = 2'b00;
   localparam  STATE_WAIT = 2'b01;
   localparam  STATE_MEM  = 2'b10;

   // ***********************************************
   // Instruction fields
   // ***********************************************

   wire [4:0]  rd      = instr[8:4];
   wire [4:0]  rr      = {instr[9], instr[3:0]};
   wire [6:0]  brk     = instr[9:3];
   wire [2:0]  bsel    = instr[2:0];
   wire        bclr    = instr[10];
   wire [5:0]  dq      = {instr[13], instr[11:10], instr[2:0]};
   wire [4:0]  wdst    = {instr[7:4], 1'b0};
   wire [4:0]  wsrc    = {instr[3:0], 1'b0};
   wire [4:0]  idst    = {1'b1, instr[7:4]};
   wire [7:0]  ival    = {instr[11:8], instr[3:0]};

   assign instr_ready = (state_reg == STATE_IDLE);

   // ***********************************************
   // Branch condition
   // ***********************************************

   reg         flag;
   wire        br_cond = bclr ? ~flag : flag;

   always @*
   begin
      case (bsel)
         `BLS_F_C: flag = sreg[`BLS_F_C];  // RULE3 RULE4
         `BLS_F_Z: flag = sreg[`BLS_F_Z];  // RULE18 RULE19
         `BLS_F_N: flag = sreg[`BLS_F_N];  // RULE19
         `BLS_F_V: flag = sreg[`BLS_F_V];  // RULE1 RULE2
         // Signed tests use N xor V directly, so a stale S cannot mislead
         `BLS_F_S: flag = sreg[`BLS_F_N] ^ sreg[`BLS_F_V];  // RULE5 RULE6
         `BLS_F_H: flag = sreg[`BLS_F_H];  // RULE7
         `BLS_F_T: flag = sreg[`BLS_F_T];  // RULE8
         `BLS_F_I: flag = sreg[`BLS_F_I];  // RULE9 RULE10
         default:  flag = 1'b0;
      endcase
   end

   // ***********************************************
   // Decode
   // ***********************************************

   reg  [2:0]  kind;
   reg  [1:0]  mode;
   reg  [1:0]  psel;
   reg         is_store;
   reg         is_direct;

   always @*
   begin
      kind      = `BLS_K_ILL;
      mode      = `BLS_M_PLAIN;
      psel      = `BLS_P_X;
      is_store  = 1'b0;
      is_direct = 1'b0;
      if (instr[15:11] == `BLS_OP_BRB)
      begin
         kind = `BLS_K_BR;
      end
      else if (instr[15:10] == `BLS_OP_MOV)
      begin
         kind = `BLS_K_MOV;
      end
      else if (instr[15:8] == `BLS_OP_PAIR)
      begin
         kind = `BLS_K_PAIR;
      end
      else if (instr[15:12] == `BLS_OP_IMM)
      begin
         kind = `BLS_K_IMM;
      end
      else if (instr[15:10] == `BLS_OP_LDST)
      begin
         is_store = instr[9];
         kind     = `BLS_K_MEM;
         case (instr[3:0])
            4'h0:
            begin
               // Direct store is not handled by this unit
               if (instr[9])
                  kind = `BLS_K_ILL;
               is_direct = 1'b1;
               mode      = `BLS_M_OFS;
            end
            4'hc: mode = `BLS_M_PLAIN;
            4'hd: mode = `BLS_M_INC;
            4'he: mode = `BLS_M_DEC;
            4'h9:
            begin
               psel = `BLS_P_Y;
               mode = `BLS_M_INC;
            end
            4'ha:
            begin
               psel = `BLS_P_Y;
               mode = `BLS_M_DEC;
            end
            4'h1:
            begin
               psel = `BLS_P_Z;
               mode = `BLS_M_INC;
            end
            4'h2:
            begin
               psel = `BLS_P_Z;
               mode = `BLS_M_DEC;
            end
            default: kind = `BLS_K_ILL;
         endcase
      end
      else if ((instr[15:14] == `BLS_OP_DISP) && !instr[12])
      begin
         // Zero displacement is the plain Y or Z form
         kind     = `BLS_K_MEM;
         is_store = instr[9];
         mode     = `BLS_M_OFS;
         psel     = instr[3] ? `BLS_P_Y : `BLS_P_Z;
      end
   end

   // ***********************************************
   // Address generation
   // ***********************************************

   wire [4:0]  pbase = `BLS_PTR_BASE + {2'h0, psel, 1'b0};
   wire [4:0]  phigh = pbase + 5'h01;
   wire [15:0] pval  = {gpr[phigh], gpr[pbase]};
   wire [15:0] pinc  = pval + 16'h0001;
   wire [15:0] pdec  = pval - 16'h0001;
   wire [15:0] pofs  = pval + {10'h000, dq};

   reg  [15:0] ea;
   reg         upd;
   reg  [15:0] pnew;

   always @*
   begin
      ea   = pval;
      upd  = 1'b0;
      pnew = pval;
      case (mode)
         `BLS_M_PLAIN: ea = pval;  // RULE20
         `BLS_M_INC:
         begin
            ea   = pval;  // RULE12 RULE16
            upd  = 1'b1;
            pnew = pinc;
         end
         `BLS_M_DEC:
         begin
            ea   = pdec;  // RULE13 RULE17
            upd  = 1'b1;
            pnew = pdec;
         end
         `BLS_M_OFS:
            ea = is_direct ? instr_ext : pofs;  // RULE14 RULE15
         default: ea = pval;
      endcase
   end

   // ***********************************************
   // Program counter step
   // ***********************************************

   wire [15:0] pc_seq = pc_reg + 16'h0001;
   wire [15:0] pc_two = pc_reg + 16'h0002;
   wire [15:0] pc_br  = pc_seq + {{9{brk[6]}}, brk};

   reg  [15:0] pc_next;

   always @*
   begin
      pc_next = pc_seq;
      if ((kind == `BLS_K_BR) && br_cond)
         pc_next = pc_br;  // RULE1 RULE2 RULE5 RULE7 RULE9 RULE18
      else if ((kind == `BLS_K_MEM) && is_direct)
         pc_next = pc_two;
   end

   // ***********************************************
   // Sequencer and register file
   // ***********************************************

   // Flags are an input only: nothing here can alter them, which is what
   // every instruction of this group demands.
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg     <= STATE_IDLE;
         pc_reg        <= 16'h0000;
         done_reg      <= 1'b0;
         taken_reg     <= 1'b0;
         illegal_reg   <= 1'b0;
         cycles_reg    <= 2'h0;
         mem_addr_reg  <= 16'h0000;
         mem_wdata_reg <= 8'h00;
         mem_we_reg    <= 1'b0;
         mem_re_reg    <= 1'b0;
         dbg_data_reg  <= 8'h00;
         dst_reg       <= 5'h00;
         store_reg     <= 1'b0;
         for (i = 0; i < 32; i = i + 1)
            gpr[i] <= 8'h00;
      end
      else
      begin
         done_reg     <= 1'b0;
         taken_reg    <= 1'b0;
         illegal_reg  <= 1'b0;
         mem_we_reg   <= 1'b0;
         mem_re_reg   <= 1'b0;
         dbg_data_reg <= gpr[dbg_addr];
         case (state_reg)
            STATE_IDLE:
            begin
               if (instr_valid)
               begin
                  pc_reg <= pc_next;
                  case (kind)
                     `BLS_K_BR:
                     begin
                        if (br_cond)
                        begin
                           state_reg <= STATE_WAIT;  // RULE3 RULE8 RULE10
                        end
                        else
                        begin
                           done_reg   <= 1'b1;  // RULE6 RULE19
                           cycles_reg <= `BLS_CYC_SHORT;
                        end
                     end
                     `BLS_K_MOV:
                     begin
                        gpr[rd]    <= gpr[rr];  // RULE11
                        done_reg   <= 1'b1;
                        cycles_reg <= `BLS_CYC_SHORT;
                     end
                     `BLS_K_PAIR:
                     begin
                        gpr[wdst]         <= gpr[wsrc];  // RULE11
                        gpr[wdst | 5'h01] <= gpr[wsrc | 5'h01];
                        done_reg          <= 1'b1;
                        cycles_reg        <= `BLS_CYC_SHORT;
                     end
                     `BLS_K_IMM:
                     begin
                        gpr[idst]  <= ival;  // RULE11
                        done_reg   <= 1'b1;
                        cycles_reg <= `BLS_CYC_SHORT;
                     end
                     `BLS_K_MEM:
                     begin
                        // Pointer is written now; the memory cycle follows
                        mem_addr_reg  <= ea;
                        mem_wdata_reg <= gpr[rd];
                        mem_we_reg    <= is_store;  // RULE16 RULE17
                        mem_re_reg    <= ~is_store;  // RULE12 RULE13
                        dst_reg       <= rd;
                        store_reg     <= is_store;
                        state_reg     <= STATE_MEM;
                        if (upd)
                        begin
                           gpr[pbase] <= pnew[7:0];  // RULE12 RULE13
                           gpr[phigh] <= pnew[15:8];
                        end
                     end
                     default:
                     begin
                        illegal_reg <= 1'b1;
                        done_reg    <= 1'b1;
                        cycles_reg  <= `BLS_CYC_SHORT;
                     end
                  endcase
               end
               else if (load_en)
               begin
                  gpr[load_addr] <= load_data;
               end
            end
            STATE_WAIT:
            begin
               state_reg  <= STATE_IDLE;
               done_reg   <= 1'b1;
               taken_reg  <= 1'b1;
               cycles_reg <= `BLS_CYC_LONG;  // RULE1 RULE4
            end
            STATE_MEM:
            begin
               // A load that names its own pointer ends with the data
               if (!store_reg)
                  gpr[dst_reg] <= mem_rdata;  // RULE14 RULE15 RULE20
               state_reg  <= STATE_IDLE;
               done_reg   <= 1'b1;
               cycles_reg <= `BLS_CYC_LONG;  // RULE16 RULE17
            end
            default: state_reg <= STATE_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> verification/bls_dmem.sv
`timescale 1ns/100ps
`default_nettype none
module bls_dmem
(
   input  wire logic        clock, // Core clock
   input  wire logic [15:0] addr,  // Byte address
   input  wire logic [7:0]  wdata, // Write data
   input  wire logic        we,    // Write strobe
   input  wire logic        re,    // Read strobe
   output logic      [7:0]  rdata  // Read data, valid while re is high
);
   // Only 256 bytes: upper address bits alias, keep tests below 0x100
   logic [7:0] mem [256];
   logic [7:0] last_reg;

   initial
   begin
      last_reg = 8'h00;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
   end

   // Idle bus shows the inverse of the last byte, never a stale match
   assign rdata = re ? mem[addr[7:0]] : ~last_reg;

   always @(posedge clock)
   begin
      if (we)
         mem[addr[7:0]] <= wdata;
      if (re)
         last_reg <= mem[addr[7:0]];
   end
endmodule
`default_nettype wire

// >>> verification/bls_exec_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bls_exec_chk
(
   input wire logic        clock,       // Core clock
   input wire logic        rst_n,       // Reset, active low
   input wire logic        instr_valid, // Instruction offered
   input wire logic [15:0] instr,       // Instruction word
   input wire logic        instr_ready, // Idle
   input wire logic [7:0]  sreg,        // Status flags
   input wire logic [15:0] pc_reg,      // Program counter
   input wire logic        done_reg,    // Completion pulse
   input wire logic        taken_reg,   // Branch taken pulse
   input wire logic [1:0]  cycles_reg,  // Cycle count
   input wire logic        mem_we_reg,  // Write strobe
   input wire logic        mem_re_reg   // Read strobe
);
   // ****************
   // Decode helpers
   // ****************
   wire acc = instr_valid && instr_ready;
   wire br  = acc && instr[15:11] == 5'h1e;
   wire flg = (instr[2:0] == 3'h4) ? sreg[2] ^ sreg[3] : sreg[instr[2:0]];
   wire tk  = flg ^ instr[10];
   wire one = acc && (instr[15:10] == 6'h0b || instr[15:8] == 8'h01 ||
                      instr[15:12] == 4'he);
   wire load_acc = acc && instr[15:9] == 7'h48 &&
              instr[3:0] inside {4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd,
                                 4'he};

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   br_take_a: assert property (br && tk |=> !instr_ready ##1
      done_reg && taken_reg && cycles_reg == 2'h2)
      else $error("taken branch timing wrong");
   br_pc_a: assert property (br && tk |=> pc_reg ==
      $past(pc_reg) + 16'h1 + {{9{$past(instr[9])}}, $past(instr[9:3])})
      else $error("branch target wrong");
   br_fall_a: assert property (br && !tk |=> done_reg &&
      !taken_reg && cycles_reg == 2'h1 && pc_reg == $past(pc_reg) + 16'h1)
      else $error("fall through wrong");
   one_cyc_a: assert property (one |=> done_reg &&
      cycles_reg == 2'h1 && !mem_we_reg && !mem_re_reg)
      else $error("single cycle move wrong");
   load_rd_a: assert property (load_acc |=> mem_re_reg &&
      !instr_ready ##1 done_reg && cycles_reg == 2'h2)
      else $error("load timing wrong");
   store_done_a: assert property (mem_we_reg |=>
      done_reg && cycles_reg == 2'h2)
      else $error("store completion wrong");
   no_clash_a: assert property (!(mem_we_reg && mem_re_reg))
      else $error("read and write together");
   taken_pulse_a: assert property (taken_reg |->
      done_reg && cycles_reg == 2'h2)
      else $error("taken without two cycle completion");

   cover property (br && tk);
   cover property (load_acc);
   cover property (mem_we_reg);
endmodule

bind bls_exec bls_exec_chk i_chk
(
   .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
   .instr_ready(instr_ready), .sreg(sreg), .pc_reg(pc_reg),
   .done_reg(done_reg), .taken_reg(taken_reg), .cycles_reg(cycles_reg),
   .mem_we_reg(mem_we_reg), .mem_re_reg(mem_re_reg)
);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clock, rst_n = 1'b0, instr_valid = 1'b0, load_en = 1'b0;
   logic        hung = 1'b0, exp_ill = 1'b0;
   logic [15:0] instr = 16'h0, instr_ext = 16'h0;
   logic [7:0]  sreg = 8'h00, load_data = 8'h00;
   logic [4:0]  load_addr = 5'h0, dbg_addr = 5'h0;
   wire         instr_ready, done_reg, taken_reg, mem_we_reg, mem_re_reg;
   wire         illegal_reg;
   wire [15:0]  pc_reg, mem_addr_reg;
   wire [7:0]   mem_wdata_reg, dbg_data_reg, mem_rdata;
   wire [1:0]   cycles_reg;
   int          n_fail = 0, tests_run = 0;
   // Branch word, flags, expected taken
   logic [31:0] rows [20] = '{
      32'hf01b0801, 32'hf41b0800, 32'hf41b0001,
      32'hf4180100, 32'hf4180001, 32'hf0180101,
      32'hf41c0c01, 32'hf01c0401, 32'hf01c0c00,
      32'hf01d2001, 32'hf41d2000, 32'hf01e0000, 32'hf41e0001,
      32'hf3f78001, 32'hf4178000, 32'hf0190201,
      32'hf4190200, 32'hf01a0401, 32'hf41a0001,
      32'hf4170001};

   bls_exec i_dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr(instr), .instr_ext(instr_ext), .instr_ready(instr_ready),
      .sreg(sreg), .pc_reg(pc_reg), .done_reg(done_reg),
      .taken_reg(taken_reg), .illegal_reg(illegal_reg),
      .cycles_reg(cycles_reg),
      .mem_addr_reg(mem_addr_reg), .mem_wdata_reg(mem_wdata_reg),
      .mem_we_reg(mem_we_reg), .mem_re_reg(mem_re_reg),
      .mem_rdata(mem_rdata), .load_en(load_en), .load_addr(load_addr),
      .load_data(load_data), .dbg_addr(dbg_addr),
      .dbg_data_reg(dbg_data_reg));
   bls_dmem i_mem (.clock(clock), .addr(mem_addr_reg), .wdata(mem_wdata_reg),
      .we(mem_we_reg), .re(mem_re_reg), .rdata(mem_rdata));

   // ****************
   // Tasks
   // ****************
   task automatic check(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic exec(input logic [15:0] w, ext, input logic [1:0] cyc,
                       input logic tk, input logic [15:0] dp);
      logic [15:0] p;
      int          n;
      @(posedge clock);
      #1;
      p = pc_reg;
      instr = w;
      instr_ext = ext;
      instr_valid = 1'b1;
      n = 0;
      @(posedge clock);
      #1;
      instr_valid = 1'b0;
      while (done_reg !== 1'b1 && n < 4)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n == 4)
         hung = 1'b1;
      check("pc", pc_reg, p + dp);
      check("cycles", 16'(cycles_reg), 16'(cyc));
      check("taken", 16'(taken_reg), 16'(tk));
      check("illegal", 16'(illegal_reg), 16'(exp_ill));
   endtask

   task automatic pre(input logic [4:0] r, input logic [7:0] d);
      @(posedge clock);
      #1;
      load_en = 1'b1;
      load_addr = r;
      load_data = d;
      @(posedge clock);
      #1;
      load_en = 1'b0;
   endtask

   task automatic rd(input logic [4:0] r, input logic [7:0] exp);
      @(posedge clock);
      #1;
      dbg_addr = r;
      @(posedge clock);
      #1;
      check("register", 16'(dbg_data_reg), 16'(exp));
   endtask

   // ****************
   // Clock, watchdog, sequence
   // ****************
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial
   begin
      for (int i = 0; i < 5000 && !hung; i++)
         @(posedge clock);
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      logic [15:0] k;
      repeat (10) @(posedge clock);
      #1;
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         sreg = rows[i][15:8];
         k = {{9{rows[i][25]}}, rows[i][25:19]} + 16'h1;
         exec(rows[i][31:16], 16'h0, rows[i][0] ? 2'h2 : 2'h1, rows[i][0],
              rows[i][0] ? k : 16'h1);
      end
      exec(16'hea05, 16'h0, 2'h1, 1'b0, 16'h1);
      rd(5'd16, 8'ha5);
      exec(16'h2e10, 16'h0, 2'h1, 1'b0, 16'h1);
      rd(5'd1, 8'ha5);
      exec(16'h0118, 16'h0, 2'h1, 1'b0, 16'h1);
      rd(5'd2, 8'ha5);
      pre(5'd26, 8'h10);
      pre(5'd27, 8'h00);
      exec(16'h904d, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd4, 8'h4a);
      rd(5'd26, 8'h11);
      exec(16'h930d, 16'h0, 2'h2, 1'b0, 16'h1);
      exec(16'h905e, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd5, 8'ha5);
      rd(5'd26, 8'h11);
      exec(16'h921e, 16'h0, 2'h2, 1'b0, 16'h1);
      exec(16'h906c, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd6, 8'ha5);
      rd(5'd26, 8'h10);
      pre(5'd28, 8'h20);
      pre(5'd29, 8'h00);
      exec(16'h808d, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd8, 8'h7f);
      rd(5'd28, 8'h20);
      exec(16'h9090, 16'h0030, 2'h2, 1'b0, 16'h2);
      rd(5'd9, 8'h6a);
      // Unhandled words and a direct store must leave memory alone
      exp_ill = 1'b1;
      exec(16'h0000, 16'h0, 2'h1, 1'b0, 16'h1);
      exec(16'h9210, 16'h0030, 2'h1, 1'b0, 16'h1);
      exp_ill = 1'b0;
      exec(16'h90e0, 16'h0030, 2'h2, 1'b0, 16'h2);
      rd(5'd14, 8'h6a);
      pre(5'd30, 8'h40);
      exec(16'h90a1, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd10, 8'h1a);
      rd(5'd30, 8'h41);
      exec(16'h82a2, 16'h0, 2'h2, 1'b0, 16'h1);
      exec(16'h80b2, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd11, 8'h1a);
      exec(16'h90d2, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd13, 8'h1a);
      rd(5'd30, 8'h40);
      exec(16'h90c9, 16'h0, 2'h2, 1'b0, 16'h1);
      rd(5'd12, 8'h7a);
      rd(5'd28, 8'h21);
      @(posedge clock);
      #1;
      rst_n = 1'b0;
      @(posedge clock);
      #1;
      check("pc", pc_reg, 16'h0);
      check("cycles", 16'(cycles_reg), 16'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
